/* File: logic/afc_pkg.sv */
// Package for the converter frame and power-mode controller.
// Assumes a 100 MHz system clock; the serial clock is made by division.
package afc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_CYC = 3;
  localparam int GAP_NS = 60;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_NS = 1000;
  localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Frame lengths in serial-clock falling edges, and result bit layout
  // ----------------------------------------------------------------
  localparam int FULL_EDGES = 16;
  localparam int WAKE_EDGES = 10;
  localparam int SLEEP_EDGES = 4;
  localparam int LEAD_ZEROS = 4;
  localparam int RESULT_BITS = 12;

  typedef enum logic [1:0] {
    AFC_CMD_CONVERT,
    AFC_CMD_WAKE,
    AFC_CMD_SLEEP
  } afc_cmd_t;

endpackage

/* File: logic/afc_fifo.sv */
// Result FIFO between the frame controller and its user.
// Assumes writer and reader share one clock.
`timescale 1ns/1ps
`default_nettype none
module afc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("Depth must be a power of two of at least two.");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: logic/afc_ctrl.sv */
// Host-side frame controller for a serial successive-approximation converter.
// Drives active-low chip select and the serial clock, reads the result bits.
// Assumes the converter's result pin arrives asynchronously to clk_i.
//
// Behaviour
// - Hold select low through ten falling edges.
// - Full conversion takes sixteen serial clocks.
// - Select may idle high between conversions.
// - Wait quiet gap before next select fall.
// - Release before edge ten enters power-down.
// - Dummy frame past edge ten wakes device.
// - Quiet gap also follows a dummy frame.
// - One dummy frame suffices up to 18 MHz.
// - Wake frame may end after edge ten.
// - Run dummy frame after supply before trusting.
// - Power-down may be forced after supply.
// - Dummy frame may follow supply at once.
// - Lower serial clock above 320 kSPS; here the half period SCLK_HALF_CYC is fixed.
// - Quiet gap is at least 60 ns.
`timescale 1ns/1ps
`default_nettype none
module afc_ctrl #(
  parameter int DEPTH = 8,
  parameter int POWERUP_WAIT = afc_pkg::POWERUP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire afc_pkg::afc_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic cs_n_o,
  output logic sclk_o,
  input wire logic serial_result_out_i,
  output logic awake_o,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [afc_pkg::RESULT_BITS-1:0] res_data_o
);
  import afc_pkg::*;

  initial begin
    if (POWERUP_WAIT < 1) begin
      $error("Power-up wait must be at least one cycle.");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum {
    AFC_IDLE,
    AFC_LOW,
    AFC_HIGH,
    AFC_GAP,
    AFC_PUSH,
    AFC_POWERUP
  } afc_state_t;

  typedef struct packed {
    afc_state_t st;
    afc_cmd_t cmd;
    logic cs_n;
    logic sclk;
    logic awake;
    logic valid_data;
    logic [4:0] edges;
    logic [3:0] half;
    logic [15:0] wait_cnt;
    logic [15:0] shift;
    logic cmd_ready;
    logic push;
  } afc_reg_t;

  afc_reg_t q;
  afc_reg_t d;
  logic sync1_q;
  logic sync2_q;
  logic fifo_ready;
  logic [4:0] target;

  // Two flops before anything reads the result pin.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= serial_result_out_i;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Frame length per command
  // ----------------------------------------------------------------
  always_comb begin
    case (q.cmd)
      AFC_CMD_WAKE: target = 5'(WAKE_EDGES);
      AFC_CMD_SLEEP: target = 5'(SLEEP_EDGES);
      default: target = 5'(FULL_EDGES);
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.cmd_ready = 1'b0;
    d.push = 1'b0;
    case (q.st)
      AFC_IDLE: begin
        d.cs_n = 1'b1;
        d.sclk = 1'b1;
        if (cmd_valid_i && q.cmd_ready) begin
          d.cmd = cmd_i;
          d.st = AFC_LOW;
          d.cs_n = 1'b0;
          d.edges = '0;
          d.half = '0;
          d.shift = '0;
        end else begin
          d.cmd_ready = 1'b1;
        end
      end
      AFC_HIGH: begin
        // The device shifts on falling edges; sample just before the next one.
        // The half period is fixed; slow it here for low-rate power savings.
        if (q.half == 4'(SCLK_HALF_CYC - 1)) begin
          d.half = '0;
          d.sclk = 1'b0;
          d.edges = q.edges + 5'd1;
          d.shift = {q.shift[14:0], sync2_q};
          d.st = AFC_LOW;
        end else begin
          d.half = q.half + 4'd1;
        end
      end
      AFC_LOW: begin
        if (q.half == 4'(SCLK_HALF_CYC - 1)) begin
          d.half = '0;
          d.sclk = 1'b1;
          if (q.edges == target) begin
            d.cs_n = 1'b1;
            d.wait_cnt = 16'(GAP_CYC);
            d.st = AFC_GAP;
          end else begin
            d.st = AFC_HIGH;
          end
        end else begin
          d.half = q.half + 4'd1;
        end
      end
      AFC_GAP: begin
        if (q.wait_cnt <= 16'd1) begin
          case (q.cmd)
            AFC_CMD_WAKE: begin
              d.awake = 1'b1;
              d.valid_data = 1'b0;
              d.wait_cnt = 16'(POWERUP_WAIT);
              d.st = AFC_POWERUP;
            end
            AFC_CMD_SLEEP: begin
              d.awake = 1'b0;
              d.valid_data = 1'b0;
              d.st = AFC_IDLE;
            end
            default: begin
              // The first full frame after supply is treated as the dummy.
              // A full frame outlasts the power-up time, so the next result is good.
              d.valid_data = 1'b1;
              d.awake = 1'b1;
              d.st = q.valid_data ? AFC_PUSH : AFC_IDLE;
            end
          endcase
        end else begin
          d.wait_cnt = q.wait_cnt - 16'd1;
        end
      end
      AFC_POWERUP: begin
        if (q.wait_cnt <= 16'd1) begin
          d.valid_data = 1'b1;
          d.st = AFC_IDLE;
        end else begin
          d.wait_cnt = q.wait_cnt - 16'd1;
        end
      end
      AFC_PUSH: begin
        // A full FIFO stalls the sequencer here, holding off new frames.
        if (fifo_ready) begin
          d.push = 1'b1;
          d.st = AFC_IDLE;
        end
      end
      default: begin
        d.st = AFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st: AFC_IDLE, cmd: AFC_CMD_CONVERT, cs_n: 1'b1, sclk: 1'b1,
             awake: 1'b0, valid_data: 1'b0, edges: '0, half: '0,
             wait_cnt: '0, shift: '0, cmd_ready: 1'b0, push: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign cs_n_o = q.cs_n;
  assign sclk_o = q.sclk;
  assign awake_o = q.awake;
  assign cmd_ready_o = q.cmd_ready;

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  afc_fifo #(
    .WIDTH(RESULT_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(q.push),
    .in_ready_o(fifo_ready),
    .in_data_i(q.shift[RESULT_BITS-1:0]),
    .out_valid_o(res_valid_o),
    .out_ready_i(res_ready_i),
    .out_data_o(res_data_o)
  );
endmodule
`default_nettype wire

/* File: test/afc_conv_model.sv */
// Converter model on the far side of the frame controller.
// Assumes the host drives select and serial clock from its own clock.
`timescale 1ns/1ps
`default_nettype none
module afc_conv_model (
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [11:0] val_i,
  output logic sdo_o
);
  logic pwr = 1'h0;
  logic drv = 1'h0;
  logic [15:0] sh = 16'h0000;
  int n = 0;
  initial sdo_o = 1'h0;
  // Data taken while asleep is corrupted, so a host that trusts it fails.
  always @(negedge cs_n_i) begin
    n = 0;
    sh = {4'h0, pwr ? val_i : ~val_i};
    sdo_o = 1'h0;
    drv = 1'h1;
  end
  always @(negedge sclk_i) begin
    if (!cs_n_i && drv) begin
      n = n + 1;
      if (n >= 16) begin
        sdo_o = ~sdo_o;
        drv = 1'h0;
      end else begin
        sdo_o = sh[15-n];
      end
    end
  end
  always @(posedge cs_n_i) begin
    if (n >= 10) pwr = 1'h1;
    else if (n >= 2) pwr = 1'h0;
    if (drv) sdo_o = ~sdo_o;
    drv = 1'h0;
  end
endmodule
`default_nettype wire

/* File: test/afc_ctrl_sva.sv */
// Checker on the frame controller ports.
// Assumes afc_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
module afc_ctrl_chk #(
  parameter int DEPTH = 8,
  parameter int POWERUP_WAIT = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire afc_pkg::afc_cmd_t cmd_i,
  input wire logic cmd_ready_o,
  input wire logic cs_n_o,
  input wire logic sclk_o,
  input wire logic serial_result_out_i,
  input wire logic awake_o,
  input wire logic res_valid_o,
  input wire logic res_ready_i,
  input wire logic [afc_pkg::RESULT_BITS-1:0] res_data_o
);
  import afc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic s_q;
  logic [4:0] n_q;
  afc_cmd_t c_q;
  // Falling edges are counted per frame to judge where select was released.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= 1'h1;
      n_q <= 5'h00;
      c_q <= AFC_CMD_CONVERT;
    end else begin
      s_q <= sclk_o;
      if (cs_n_o) n_q <= 5'h00;
      else if (s_q && !sclk_o) n_q <= n_q + 5'h01;
      if (cmd_valid_i && cmd_ready_o) c_q <= cmd_i;
    end
  end
  a_edge_count: assert property ($rose(cs_n_o) |-> n_q == (c_q == AFC_CMD_WAKE ? 5'h0A :
    c_q == AFC_CMD_SLEEP ? 5'h04 : 5'h10)) else $error("wrong edge count");
  a_take_frame: assert property (cmd_valid_i && cmd_ready_o |=> !cs_n_o && !cmd_ready_o)
    else $error("frame not started");
  a_gap_hold: assert property ($rose(cs_n_o) |-> cs_n_o [*6])
    else $error("gap too short");
  a_sclk_idle: assert property (cs_n_o |-> sclk_o) else $error("clock not idle");
  a_sclk_low: assert property ($fell(sclk_o) |-> !sclk_o [*3] ##1 sclk_o)
    else $error("clock low phase");
  a_busy_frame: assert property (!cs_n_o |-> !cmd_ready_o) else $error("ready in frame");
  a_sleep_flag: assert property ($rose(cs_n_o) && c_q == AFC_CMD_SLEEP |-> ##[0:8] !awake_o)
    else $error("awake after sleep");
  a_wake_flag: assert property ($rose(cs_n_o) && c_q == AFC_CMD_WAKE |-> ##[1:300] awake_o)
    else $error("not awake");
  a_res_hold: assert property (res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
    else $error("result dropped");
endmodule
bind afc_ctrl afc_ctrl_chk #(.DEPTH(DEPTH), .POWERUP_WAIT(POWERUP_WAIT)) afc_ctrl_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .cmd_ready_o(cmd_ready_o), .cs_n_o(cs_n_o), .sclk_o(sclk_o), .awake_o(awake_o),
  .serial_result_out_i(serial_result_out_i), .res_valid_o(res_valid_o),
  .res_ready_i(res_ready_i), .res_data_o(res_data_o));
`default_nettype wire

/* File: test/tb_afc_ctrl.sv */
// Bench for the frame controller against a converter model.
// Assumes package, FIFO, controller, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_afc_ctrl;
  import afc_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cmd_valid_i = 1'h0;
  afc_cmd_t cmd_i = AFC_CMD_CONVERT;
  logic res_ready_i = 1'h0;
  logic [11:0] val = 12'h000;
  logic cmd_ready_o, cs_n_o, sclk_o, sdo, awake_o, res_valid_o;
  logic [RESULT_BITS-1:0] res_data_o;
  logic [11:0] exp_q[$];
  logic [31:0] rng = 32'h00000031;
  logic [31:0] rr = 32'h00000031;
  logic awake_e = 1'h0;
  logic stall = 1'h1;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  afc_ctrl #(.DEPTH(8), .POWERUP_WAIT(2)) afc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cs_n_o(cs_n_o),
    .sclk_o(sclk_o), .serial_result_out_i(sdo), .awake_o(awake_o),
    .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_data_o(res_data_o));
  afc_conv_model afc_conv_model_inst (.cs_n_i(cs_n_o), .sclk_i(sclk_o), .val_i(val),
    .sdo_o(sdo));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A result is owed only when the host already believed the converter awake.
  task automatic issue(input afc_cmd_t c, input bit fin);
    rng = xs(rng);
    val <= rng[11:0];
    if (c == AFC_CMD_CONVERT && awake_e) exp_q.push_back(rng[11:0]);
    awake_e = (c != AFC_CMD_SLEEP);
    cmd_i <= c;
    cmd_valid_i <= 1'h1;
    @(negedge clk_i);
    while (cmd_ready_o !== 1'h1) @(negedge clk_i);
    @(posedge clk_i);
    cmd_valid_i <= 1'h0;
    if (fin) begin
      @(negedge clk_i);
      while (cmd_ready_o !== 1'h1) @(negedge clk_i);
      chk("awake", {11'h000, awake_e}, {11'h000, awake_o});
      @(posedge clk_i);
    end
  endtask
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    // Ready draws a fresh value every cycle but is held low while stall is set, so the FIFO fills.
    rr <= xs(rr);
    res_ready_i <= !stall && rr[4];
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  always @(negedge clk_i) begin
    if (res_valid_o === 1'h1 && res_ready_i) begin
      chk("result", exp_q.size() != 0 ? exp_q.pop_front() : 12'hXXX, res_data_o);
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    stall = 1'h0;
    issue(AFC_CMD_CONVERT, 1);
    issue(AFC_CMD_SLEEP, 1);
    issue(AFC_CMD_CONVERT, 1);
    issue(AFC_CMD_WAKE, 1);
    repeat (30) begin
      rng = xs(rng);
      issue(afc_cmd_t'(rng[1:0] % 2'h3), 1);
    end
    stall = 1'h1;
    issue(AFC_CMD_WAKE, 1);
    repeat (8) issue(AFC_CMD_CONVERT, 1);
    issue(AFC_CMD_CONVERT, 0);
    repeat (200) @(posedge clk_i);
    chk("stalled", 12'h000, {11'h000, cmd_ready_o});
    stall = 1'h0;
    repeat (600) @(posedge clk_i);
    chk("left", 12'h000, 12'(exp_q.size()));
    stop_test();
  end
endmodule
`default_nettype wire
